// >>> hdl/lrc_top.sv
// Purpose: Per-link retry control and status register with retry attempt tracking.
// Assumes: rst_i is the cold reset; warm_rst_i is a one-cycle warm reset pulse on clk_i.
// Notes: Link events arrive on the link clock and are captured by lrc_link_cap.
// Notes on behaviour
// - Sixteen-bit event counter, read-write, cold reset zero.
// - Each failed training attempt adds one.
// - Each packet error causing retry adds one.
// - Counter wraps at maximum and sets wrap flag.
// - Remote-started retries never advance the counter.
// - Sent corrupt-marked data sets bit twelve.
// - Reconnect initialization failure sets bit eleven.
// - Received stomped packet sets bit ten.
// - Any locally initiated retry sets bit eight.
// - Flags clear by writing one, cold reset zero.
// - Fast rate: budget sets short retries, then long.
// - Slow rate ignores the short retry budget.
// - Data retry disable acknowledges bad data packets.
// - Any retry disable acknowledges every bad packet.
// - Force bit corrupts one CRC, then self-clears.
// - Retry mode arm applies at next warm reset.
// - Attempt counter counts only local errors.
// - Link fails at limit plus one errors.
// - Without capability the register reads reserved.
//
// Chosen here: the address map and the Wishbone register port.
`default_nettype none
module lrc_top import lrc_pkg::*; #(
    parameter bit LINK_RETRY_CAP = 1'b1
) (
    // Clock and resets.
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic warm_rst_i,
    // Classic Wishbone slave.
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Link pins.
    input wire logic link_clk_i,
    input wire logic [LRC_EV_N-1:0] link_ev_i,
    // Retry control towards the link sequencers.
    output logic retry_start_o,
    output logic ack_bad_o,
    output logic force_crc_o,
    output logic long_retry_o,
    output logic link_failed_o,
    output logic retry_mode_o
);
    lrc_ev_if ev_bus ();

    lrc_link_cap u_cap (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .link_clk_i(link_clk_i),
        .link_ev_i(link_ev_i),
        .ev(ev_bus.cap)
    );

    // Byte-enable mask for a 32-bit word.
    function automatic logic [31:0] sel_mask(input logic [3:0] sel);
        sel_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    endfunction

    // Merge written bytes into an old value.
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] sel);
        merge = (old & ~sel_mask(sel)) | (wd & sel_mask(sel));
    endfunction

    logic [15:0] cnt, next_cnt;
    logic [4:0] flags, next_flags;
    logic [1:0] short_bud, next_short_bud;
    logic dis_data, next_dis_data;
    logic dis_any, next_dis_any;
    logic force_bit, next_force_bit;
    logic arm, next_arm;
    logic [2:0] limit, next_limit;
    logic fast, next_fast;
    logic [3:0] att, next_att;
    lrc_phase_e phase, next_phase;
    logic ack, next_ack;
    logic [31:0] rdat, next_rdat;
    logic mode_act, next_mode_act;
    logic start_q, next_start_q;
    logic ack_bad_q, next_ack_bad_q;
    logic force_q, next_force_q;
    logic long_q, next_long_q, failed_q, next_failed_q;

    logic [LRC_EV_N-1:0] ev;
    logic req, wr_ret, wr_ctrl, err_retry;
    logic [1:0] start_n;
    logic [16:0] cnt_sum;
    logic [3:0] att_sum;
    logic [31:0] ret_word, ctrl_word, stat_word, ret_new, ctrl_new;

    assign ev = ev_bus.pulse;
    assign req = wb_cyc_i && wb_stb_i && !ack;
    assign wr_ret = req && wb_we_i && wb_adr_i == LRC_RETRY_OFS && LINK_RETRY_CAP;
    assign wr_ctrl = req && wb_we_i && wb_adr_i == LRC_CTRL_OFS;

    // Read views of the three words.
    assign ret_word = {cnt, 3'h0, flags, short_bud, 2'h0, dis_data, dis_any, force_bit, arm};
    assign ctrl_word = {27'h0, fast, 1'b0, limit};
    assign stat_word = {21'h0, phase == PH_LONG, mode_act, phase == PH_FAILED, 4'h0, att};
    assign ret_new = merge(ret_word, wb_dat_i, wb_sel_i);
    assign ctrl_new = merge(ctrl_word, wb_dat_i, wb_sel_i);

    // Retry decision for one captured packet error; remote retries never enter here.
    always_comb begin
        err_retry = ev[LRC_EV_PKT_ERR] && !dis_any
            && !(dis_data && ev[LRC_EV_PKT_DATA]);
        start_n = {1'b0, ev[LRC_EV_TRAIN_FAIL]} + {1'b0, err_retry};
    end

    // Event counter, sticky flags and software fields.
    always_comb begin
        next_cnt = wr_ret ? ret_new[31:16] : cnt;
        cnt_sum = {1'b0, next_cnt} + {15'h0, start_n};
        next_cnt = cnt_sum[15:0];
        next_flags = flags;
        if (wr_ret) begin
            next_flags = flags & ~(wb_dat_i[12:8] & {5{wb_sel_i[1]}});
        end
        next_flags[LRC_F_RETRY] = next_flags[LRC_F_RETRY] | (start_n != 2'h0);
        next_flags[LRC_F_WRAP] = next_flags[LRC_F_WRAP] | cnt_sum[16];
        next_flags[LRC_F_STOMP] = next_flags[LRC_F_STOMP] | ev[LRC_EV_STOMP];
        next_flags[LRC_F_INIT] = next_flags[LRC_F_INIT] | ev[LRC_EV_INIT_FAIL];
        next_flags[LRC_F_CORRUPT] = next_flags[LRC_F_CORRUPT] | ev[LRC_EV_CORRUPT];
        next_short_bud = wr_ret ? ret_new[7:6] : short_bud;
        next_dis_data = wr_ret ? ret_new[LRC_DIS_DATA_BIT] : dis_data;
        next_dis_any = wr_ret ? ret_new[LRC_DIS_ANY_BIT] : dis_any;
        next_arm = wr_ret ? ret_new[LRC_ARM_BIT] : arm;
        next_limit = wr_ctrl ? ctrl_new[2:0] : limit;
        next_fast = wr_ctrl ? ctrl_new[LRC_FAST_BIT] : fast;
        // Injection clears the force bit; a write in the same cycle stands.
        next_force_q = force_bit && ev[LRC_EV_TX_PKT];
        next_force_bit = next_force_q ? 1'b0 : force_bit;
        if (wr_ret) begin
            next_force_bit = ret_new[LRC_FORCE_BIT];
        end
    end

    // Retry attempt tracking: short and long phases and link failure.
    always_comb begin
        att_sum = att + {2'h0, start_n};
        next_att = att;
        next_phase = phase;
        next_mode_act = mode_act;
        next_ack_bad_q = ev[LRC_EV_PKT_ERR] && !err_retry;
        if (warm_rst_i) begin
            next_mode_act = arm;
            next_att = 4'h0;
            next_phase = PH_IDLE;
        end else if (phase != PH_FAILED && start_n != 2'h0) begin
            next_att = att_sum;
            if (att_sum > {1'b0, limit}) begin
                next_phase = PH_FAILED;
            end else if (fast && att_sum > {2'h0, short_bud}) begin
                next_phase = PH_LONG;
            end else begin
                next_phase = PH_SHORT;
            end
        end else if (phase != PH_FAILED && ev[LRC_EV_RETRY_OK]) begin
            next_att = 4'h0;
            next_phase = PH_IDLE;
        end
        // The error that fails the link starts no further retry attempt.
        next_start_q = (start_n != 2'h0) && next_phase != PH_FAILED;
        next_long_q = next_phase == PH_LONG;
        next_failed_q = next_phase == PH_FAILED;
    end

    // Bus answer: one cycle after the request, zero for unmapped words.
    always_comb begin
        next_ack = req;
        next_rdat = 32'h0;
        if (req && !wb_we_i) begin
            case (wb_adr_i)
                LRC_RETRY_OFS: next_rdat = LINK_RETRY_CAP ? ret_word : 32'h0;
                LRC_CTRL_OFS: next_rdat = ctrl_word;
                LRC_STAT_OFS: next_rdat = stat_word;
                default: next_rdat = 32'h0;
            endcase
        end
    end

    // State registers.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt <= 16'h0;
            flags <= 5'h0;
            short_bud <= LRC_SHORT_RST;
            dis_data <= 1'b0;
            dis_any <= 1'b0;
            force_bit <= 1'b0;
            arm <= 1'b0;
            limit <= LRC_LIMIT_RST;
            fast <= 1'b0;
            att <= 4'h0;
            phase <= PH_IDLE;
            ack <= 1'b0;
            rdat <= 32'h0;
            mode_act <= 1'b0;
            start_q <= 1'b0;
            ack_bad_q <= 1'b0;
            force_q <= 1'b0;
            long_q <= 1'b0;
            failed_q <= 1'b0;
        end else begin
            cnt <= next_cnt;
            flags <= next_flags;
            short_bud <= next_short_bud;
            dis_data <= next_dis_data;
            dis_any <= next_dis_any;
            force_bit <= next_force_bit;
            arm <= next_arm;
            limit <= next_limit;
            fast <= next_fast;
            att <= next_att;
            phase <= next_phase;
            ack <= next_ack;
            rdat <= next_rdat;
            mode_act <= next_mode_act;
            start_q <= next_start_q;
            ack_bad_q <= next_ack_bad_q;
            force_q <= next_force_q;
            long_q <= next_long_q;
            failed_q <= next_failed_q;
        end
    end

    // Outputs straight from flip-flops.
    assign wb_ack_o = ack;
    assign wb_dat_o = rdat;
    assign retry_start_o = start_q;
    assign ack_bad_o = ack_bad_q;
    assign force_crc_o = force_q;
    assign long_retry_o = long_q;
    assign link_failed_o = failed_q;
    assign retry_mode_o = mode_act;

    // Checks on the core domain.
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    AST_TRAIN_INC: assert property (ev[LRC_EV_TRAIN_FAIL] && !ev[LRC_EV_PKT_ERR] && !wr_ret
        |=> cnt == $past(cnt) + 16'h1) else $error("Counter did not advance on training failure.");
    AST_ERR_INC: assert property (err_retry && !ev[LRC_EV_TRAIN_FAIL] && !wr_ret
        |=> cnt == $past(cnt) + 16'h1 && retry_start_o == !link_failed_o)
        else $error("Counter or retry start wrong on packet error.");
    AST_WRAP: assert property (start_n != 2'h0 && cnt == LRC_CNT_MAX && !wr_ret
        |=> cnt[15:1] == 15'h0 && flags[LRC_F_WRAP]) else $error("Counter wrap not handled.");
    AST_REMOTE: assert property (ev[LRC_EV_REMOTE] && start_n == 2'h0 && !wr_ret
        |=> $stable(cnt) && $stable(att)) else $error("Remote retry changed a counter.");
    AST_SET_WINS: assert property (ev[LRC_EV_CORRUPT] |=> flags[LRC_F_CORRUPT])
        else $error("Corrupt-data event lost.");
    AST_W1C: assert property (wr_ret && wb_sel_i[1] && wb_dat_i[LRC_FLAG_LSB + LRC_F_STOMP]
        && !ev[LRC_EV_STOMP] |=> !flags[LRC_F_STOMP]) else $error("Stomp flag did not clear.");
    AST_DIS_ANY: assert property (ev[LRC_EV_PKT_ERR] && dis_any && !ev[LRC_EV_TRAIN_FAIL]
        |=> ack_bad_o && !retry_start_o) else $error("Retry started while disabled.");
    AST_DIS_DATA: assert property (ev[LRC_EV_PKT_ERR] && ev[LRC_EV_PKT_DATA] && dis_data
        && !ev[LRC_EV_TRAIN_FAIL] |=> ack_bad_o && !retry_start_o) else $error("Data retry started while disabled.");
    AST_FORCE: assert property (force_bit && ev[LRC_EV_TX_PKT] && !wr_ret
        |=> force_crc_o && !force_bit ##1 !force_crc_o) else $error("Forced CRC error not single.");
    AST_FAIL: assert property (phase != PH_FAILED && !warm_rst_i && att_sum > {1'b0, limit}
        && start_n != 2'h0 |=> link_failed_o [*2] or warm_rst_i) else $error("Link failure not declared.");
    AST_MODE: assert property ($rose(mode_act) |-> $past(warm_rst_i) && $past(arm))
        else $error("Retry mode changed without warm reset.");

    COV_WRAP: cover property (cnt_sum[16]);
    COV_LONG: cover property (phase == PH_SHORT ##[1:200] phase == PH_LONG);
    COV_FAIL: cover property (link_failed_o);
    COV_FORCE: cover property (force_crc_o);
endmodule
`default_nettype wire

// >>> common/lrc_pkg.sv
// Purpose: Shared constants for the link retry control and status block.
// Assumes: Registers sit on a 32-bit classic Wishbone bus, one word each.
// Notes: Event indices number the link event pins and their captured pulses.
`default_nettype none
package lrc_pkg;
    // Register byte offsets.
    localparam logic [7:0] LRC_RETRY_OFS = 8'h00;
    localparam logic [7:0] LRC_CTRL_OFS = 8'h04;
    localparam logic [7:0] LRC_STAT_OFS = 8'h08;
    // Retry register field positions.
    localparam int LRC_CNT_LSB = 16;
    localparam int LRC_FLAG_LSB = 8;
    localparam int LRC_SHORT_LSB = 6;
    localparam int LRC_DIS_DATA_BIT = 3;
    localparam int LRC_DIS_ANY_BIT = 2;
    localparam int LRC_FORCE_BIT = 1;
    localparam int LRC_ARM_BIT = 0;
    // Flag positions inside the five-bit sticky group.
    localparam int LRC_F_RETRY = 0;
    localparam int LRC_F_WRAP = 1;
    localparam int LRC_F_STOMP = 2;
    localparam int LRC_F_INIT = 3;
    localparam int LRC_F_CORRUPT = 4;
    // Control and status register field positions.
    localparam int LRC_LIMIT_LSB = 0;
    localparam int LRC_FAST_BIT = 4;
    localparam int LRC_FAILED_BIT = 8;
    localparam int LRC_MODE_BIT = 9;
    localparam int LRC_LONG_BIT = 10;
    // Reset values and the counter maximum.
    localparam logic [1:0] LRC_SHORT_RST = 2'h3;
    localparam logic [2:0] LRC_LIMIT_RST = 3'h7;
    localparam logic [15:0] LRC_CNT_MAX = 16'hffff;
    // Link event indices.
    localparam int LRC_EV_TRAIN_FAIL = 0;
    localparam int LRC_EV_PKT_ERR = 1;
    localparam int LRC_EV_PKT_DATA = 2;
    localparam int LRC_EV_REMOTE = 3;
    localparam int LRC_EV_STOMP = 4;
    localparam int LRC_EV_INIT_FAIL = 5;
    localparam int LRC_EV_CORRUPT = 6;
    localparam int LRC_EV_TX_PKT = 7;
    localparam int LRC_EV_RETRY_OK = 8;
    localparam int LRC_EV_N = 9;
    // Retry phase of the link.
    typedef enum logic [1:0] {PH_IDLE, PH_SHORT, PH_LONG, PH_FAILED} lrc_phase_e;
endpackage
`default_nettype wire

// >>> common/lrc_ev_if.sv
// Purpose: Carries captured link event pulses from the capture stage to the core.
// Assumes: Pulses are one core clock wide.
// Notes: Indices follow the event numbering of the package.
`default_nettype none
interface lrc_ev_if import lrc_pkg::*; ();
    logic [LRC_EV_N-1:0] pulse;
    modport cap (output pulse);
    modport core (input pulse);
endinterface
`default_nettype wire

// >>> hdl/lrc_link_cap.sv
// Purpose: Samples the link clock and event pins and turns link-clock edges into core pulses.
// Assumes: Link clock is far slower than clk_i, so one core cycle per link edge is enough.
// Notes: Events are levels that the link side holds across one link clock rising edge.
`default_nettype none
module lrc_link_cap import lrc_pkg::*; (
    // Core clock and reset.
    input wire logic clk_i,
    input wire logic rst_i,
    // Link side pins.
    input wire logic link_clk_i,
    input wire logic [LRC_EV_N-1:0] link_ev_i,
    // Captured pulses.
    lrc_ev_if.cap ev
);
    logic [LRC_EV_N:0] meta;
    logic [LRC_EV_N:0] sync;
    logic clk_prev;
    logic [LRC_EV_N-1:0] pulse;
    logic [LRC_EV_N:0] next_meta;
    logic [LRC_EV_N:0] next_sync;
    logic next_clk_prev;
    logic [LRC_EV_N-1:0] next_pulse;

    // Two-stage synchroniser; only the second stage is read by the edge logic.
    always_comb begin
        next_meta = {link_clk_i, link_ev_i};
        next_sync = meta;
        next_clk_prev = sync[LRC_EV_N];
        next_pulse = '0;
        if (sync[LRC_EV_N] && !clk_prev) begin
            next_pulse = sync[LRC_EV_N-1:0];
        end
    end

    // State registers.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta <= '0;
            sync <= '0;
            clk_prev <= 1'b0;
            pulse <= '0;
        end else begin
            meta <= next_meta;
            sync <= next_sync;
            clk_prev <= next_clk_prev;
            pulse <= next_pulse;
        end
    end

    assign ev.pulse = pulse;
endmodule
`default_nettype wire

// >>> dv/lrc_link_peer.sv
// Purpose: Peer link agent model that sends one event set per link clock frame.
// Assumes: Frames are requested one at a time by the bench.
// Notes: The link clock idles low between frames; released event lines invert.
`default_nettype none
module lrc_link_peer import lrc_pkg::*; (
    // Bench side.
    input wire logic clk_i,
    input wire logic go_i,
    input wire logic [LRC_EV_N-1:0] ev_i,
    output logic busy_o,
    // Link pins.
    output logic link_clk_o,
    output logic [LRC_EV_N-1:0] link_ev_o
);
    timeunit 1ns;
    timeprecision 100ps;
    // Idle state of the pins.
    initial begin
        busy_o = 1'b0;
        link_clk_o = 1'b0;
        link_ev_o = '0;
    end
    // One frame: levels settle, one 80 ns link clock high pulse, then the lines are released.
    always @(posedge clk_i) begin
        if (go_i && !busy_o) begin
            #1 busy_o = 1'b1;
            link_ev_o = ev_i;
            #42 link_clk_o = 1'b1;
            #80 link_clk_o = 1'b0;
            #20 link_ev_o = ~link_ev_o;
            busy_o = 1'b0;
        end
    end
endmodule
`default_nettype wire

// >>> dv/lrc_top_tb_top.sv
// Purpose: Self-checking bench for the link retry control and status block.
// Assumes: Link events come from the peer model, one set per frame.
// Notes: Reads queue their expected word; a monitor compares it at ack.
`default_nettype none
module lrc_top_tb_top import lrc_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_i, rst_i, warm_rst_i, cyc, stb, we, go, busy, link_clk, wb_ack_o;
    logic retry_start_o, ack_bad_o, force_crc_o, long_retry_o, link_failed_o, retry_mode_o;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] wdat, wb_dat_o, nocap_dat;
    logic [LRC_EV_N-1:0] link_ev, pev;
    logic [15:0] cnt;
    logic [31:0] q_exp[$];
    string q_name[$];
    int num_errors, tests_run, n_rs, n_ab, n_fc;

    lrc_top uut (.clk_i(clk_i), .rst_i(rst_i), .warm_rst_i(warm_rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .link_clk_i(link_clk), .link_ev_i(link_ev), .retry_start_o(retry_start_o),
        .ack_bad_o(ack_bad_o), .force_crc_o(force_crc_o), .long_retry_o(long_retry_o),
        .link_failed_o(link_failed_o), .retry_mode_o(retry_mode_o));
    // Same block without retry capability; its retry word must read as reserved.
    lrc_top #(.LINK_RETRY_CAP(1'b0)) uut_nocap (.clk_i(clk_i), .rst_i(rst_i), .warm_rst_i(warm_rst_i),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(nocap_dat), .wb_ack_o(), .link_clk_i(link_clk), .link_ev_i(link_ev), .retry_start_o(),
        .ack_bad_o(), .force_crc_o(), .long_retry_o(), .link_failed_o(), .retry_mode_o());
    lrc_link_peer peer (.clk_i(clk_i), .go_i(go), .ev_i(pev), .busy_o(busy), .link_clk_o(link_clk),
        .link_ev_o(link_ev));

    // Core clock at 200 MHz.
    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end

    // Counts the one-cycle control pulses.
    always @(posedge clk_i) begin
        n_rs <= n_rs + int'(retry_start_o === 1'b1);
        n_ab <= n_ab + int'(ack_bad_o === 1'b1);
        n_fc <= n_fc + int'(force_crc_o === 1'b1);
    end

    // Compares one value and counts the outcome.
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Takes the oldest read note whenever read data is acknowledged.
    always @(posedge clk_i) begin
        if (wb_ack_o === 1'b1 && we === 1'b0 && q_exp.size() > 0) begin
            check(q_name.pop_front(), q_exp.pop_front(), wb_dat_o);
            if (adr == LRC_RETRY_OFS) check("reserved word", 32'h0, nocap_dat);
        end
    end

    // One classic Wishbone cycle, held until ack is sampled high.
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1);
        check("bus ack cycles", 32'h2, 32'(n));
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    // Read that notes its expected word first.
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input string what);
        q_exp.push_back(e);
        q_name.push_back(what);
        wb(1'b0, a, 32'h0);
    endtask

    // Sends one link frame and checks the pulse counts it caused.
    task automatic ev(input logic [LRC_EV_N-1:0] bits, input int drs, input int dab, input int dfc);
        int rs0, ab0, fc0, i;
        rs0 = n_rs;
        ab0 = n_ab;
        fc0 = n_fc;
        @(posedge clk_i);
        go <= 1'b1;
        pev <= bits;
        @(posedge clk_i);
        go <= 1'b0;
        for (i = 0; i < 100 && (i < 2 || busy); i++) @(posedge clk_i);
        repeat (10) @(posedge clk_i);
        check("retry starts", 32'(rs0 + drs), 32'(n_rs));
        check("bad acks", 32'(ab0 + dab), 32'(n_ab));
        check("crc forces", 32'(fc0 + dfc), 32'(n_fc));
    endtask

    // One-cycle warm reset pulse.
    task automatic warm();
        @(posedge clk_i);
        warm_rst_i <= 1'b1;
        @(posedge clk_i);
        warm_rst_i <= 1'b0;
        @(posedge clk_i);
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Cuts a hang short.
    initial begin
        #200us;
        num_errors++;
        $display("[FAIL] watchdog expected end seen timeout");
        conclude();
    end

    // Main sequence.
    initial begin
        {rst_i, warm_rst_i, cyc, stb, we, go, adr, wdat, pev} = '0;
        {num_errors, tests_run, n_rs, n_ab, n_fc} = '0;
        sel = 4'hf;
        void'($urandom(16));
        rst_i = 1'b1;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(LRC_RETRY_OFS, 32'h0000_00c0, "retry word");
        rd(LRC_CTRL_OFS, 32'h0000_0007, "ctrl word");
        rd(LRC_STAT_OFS, 32'h0000_0000, "status word");
        rd(8'h0c, 32'h0, "unmapped word");
        $display("test reset done");
        cnt = 16'($urandom_range(16'hfff0));
        wb(1'b1, LRC_RETRY_OFS, {cnt, 16'h00c0});
        rd(LRC_RETRY_OFS, {cnt, 16'h00c0}, "counter");
        ev(9'h002, 1, 0, 0);
        rd(LRC_RETRY_OFS, {cnt + 16'h1, 16'h01c0}, "counter");
        ev(9'h001, 1, 0, 0);
        ev(9'h008, 0, 0, 0);
        rd(LRC_RETRY_OFS, {cnt + 16'h2, 16'h01c0}, "counter");
        rd(LRC_STAT_OFS, 32'h0000_0002, "attempts");
        $display("test counting done");
        wb(1'b1, LRC_RETRY_OFS, 32'hffff_00c0);
        ev(9'h001, 1, 0, 0);
        rd(LRC_RETRY_OFS, 32'h0000_03c0, "wrap");
        for (int i = 0; i < 3; i++) ev(9'(9'h010 << i), 0, 0, 0);
        rd(LRC_RETRY_OFS, 32'h0000_1fc0, "flags");
        wb(1'b1, LRC_RETRY_OFS, 32'h0000_1fc0);
        rd(LRC_RETRY_OFS, 32'h0000_00c0, "flag clear");
        $display("test flags done");
        warm();
        wb(1'b1, LRC_RETRY_OFS, 32'h0000_00c8);
        ev(9'h006, 0, 1, 0);
        ev(9'h002, 1, 0, 0);
        // Keeps the counter at one so that the disable read shows the earlier increment.
        wb(1'b1, LRC_RETRY_OFS, 32'h0001_00c4);
        ev(9'h002, 0, 1, 0);
        rd(LRC_RETRY_OFS, 32'h0001_01c4, "disables");
        $display("test disables done");
        wb(1'b1, LRC_RETRY_OFS, 32'h0001_00c2);
        ev(9'h080, 0, 0, 1);
        ev(9'h080, 0, 0, 0);
        rd(LRC_RETRY_OFS, 32'h0001_01c0, "force");
        wb(1'b1, LRC_RETRY_OFS, 32'h0001_00c1);
        check("mode early", 32'h0, 32'(retry_mode_o));
        warm();
        check("mode armed", 32'h1, 32'(retry_mode_o));
        rd(LRC_STAT_OFS, 32'h0000_0200, "status mode");
        $display("test force and arm done");
        for (int f = 0; f < 2; f++) begin
            wb(1'b1, LRC_CTRL_OFS, 32'(f * 16 + 3));
            wb(1'b1, LRC_RETRY_OFS, 32'h0000_0041);
            warm();
            for (int k = 1; k < 5; k++) begin
                ev(9'h002, int'(k < 4), 0, 0);
                if (k < 4) check("long", 32'(f == 1 && k > 1), 32'(long_retry_o));
                check("failed", 32'(k == 4), 32'(link_failed_o));
            end
        end
        $display("test budget and failure done");
        conclude();
    end
endmodule
`default_nettype wire
